/* File: rtl/fswp_status_protect.sv */
`timescale 1ns/10ps
module fswp_status_protect (
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   input  wire logic                 sckPin,
   input  wire logic                 chipEnableN,
   input  wire logic                 serialIn,
   input  wire logic                 protectPinN,
   input  wire logic                 regionProtected,
   input  wire logic                 opDone,
   output fswp_pkg::fswp_status_t    status,
   output logic                      serialOut,
   output logic                      serialOutEn,
   output logic                      startOp,
   output fswp_pkg::fswp_op_t        startKind,
   output logic [7:0]                lastCmd,
   output logic                      suspendReq,
   output logic                      writeProtectActive,
   output logic                      holdResetActive
);
   import fswp_pkg::*;

   // Every pin passes two flip-flops; the link clock keeps a third for edges
   logic [2:0] sckSync;
   logic [1:0] ceSync;
   logic [1:0] siSync;
   logic [1:0] wpSync;
   logic       ceDly;
   logic       next_ceDly;
   logic [2:0] next_sckSync;
   logic [1:0] next_ceSync;
   logic [1:0] next_siSync;
   logic [1:0] next_wpSync;
   logic       sckRise;
   logic       sckFall;
   logic       ceLow;
   logic       ceRise;

   always_comb begin
      next_sckSync = {sckSync[1:0], sckPin};
      next_ceSync  = {ceSync[0], chipEnableN};
      next_siSync  = {siSync[0], serialIn};
      next_wpSync  = {wpSync[0], protectPinN};
      next_ceDly   = ceSync[1];
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sckSync <= 3'h0;
         // Select and protect pins idle high, so no false edge after reset
         ceSync  <= 2'h3;
         siSync  <= 2'h0;
         wpSync  <= 2'h3;
         ceDly   <= 1'b1;
      end else begin
         sckSync <= next_sckSync;
         ceSync  <= next_ceSync;
         siSync  <= next_siSync;
         wpSync  <= next_wpSync;
         ceDly   <= next_ceDly;
      end
   end

   // Edge detection reads only the second stage and beyond
   assign sckRise = sckSync[1] & ~sckSync[2];
   assign sckFall = ~sckSync[1] & sckSync[2];
   assign ceLow   = ~ceSync[1];
   assign ceRise  = ceSync[1] & ~ceDly;

   // Frame decode state: opcode, data byte and the read shifter
   fswp_status_t sr;
   fswp_status_t next_sr;
   logic [3:0]   bitCnt;
   logic [3:0]   next_bitCnt;
   logic [7:0]   shiftIn;
   logic [7:0]   next_shiftIn;
   logic [7:0]   cmd;
   logic [7:0]   next_cmd;
   logic         cmdValid;
   logic         next_cmdValid;
   logic [7:0]   wrData;
   logic [7:0]   next_wrData;
   logic         dataValid;
   logic         next_dataValid;
   logic         bitsOdd;
   logic         next_bitsOdd;
   logic         reading;
   logic         next_reading;
   logic [7:0]   outShift;
   logic [7:0]   next_outShift;

   logic         next_serialOut;
   logic         next_serialOutEn;
   fswp_op_t     op;
   fswp_op_t     next_op;
   logic         next_startOp;
   fswp_op_t     next_startKind;
   logic [7:0]   next_lastCmd;
   logic         next_suspendReq;

   logic         needsLatch;
   logic         isProgErase;
   logic         srLocked;
   logic [7:0]   byteNow;
   logic         byteDone;

   // Byte as it stands once the current bit is shifted in
   assign byteNow  = {shiftIn[6:0], siSync[1]};
   assign byteDone = sckRise && ceLow && (bitCnt == BIT_CNT_LAST);
   // Lock follows the synchronised pin, so it lags a pin change slightly
   assign srLocked = sr.statusLockBit && !wpSync[1];

   always_comb begin
      // Write-class decode; anything not listed needs no latch
      unique case (cmd)
         PAGE_PROGRAM_CMD, QUAD_PAGE_PROGRAM_CMD, QUAD_PAGE_PROGRAM_CMD2,
         SECTOR_ERASE_CMD, SECTOR_ERASE_CMD2, BLOCK32_ERASE_CMD,
         BLOCK64_ERASE_CMD, CHIP_ERASE_CMD, CHIP_ERASE_CMD2,
         INFO_ROW_ERASE_CMD, INFO_ROW_PROGRAM_CMD: begin
            isProgErase = 1'b1;
            needsLatch  = 1'b1;
         end
         STATUS_WRITE_CMD, FUNCTION_REG_WRITE_CMD, NV_READ_PARAM_SET_CMD,
         NV_EXT_READ_PARAM_SET_CMD, AUTOBOOT_WRITE_CMD: begin
            isProgErase = 1'b0;
            needsLatch  = 1'b1;
         end
         default: begin
            // Volatile parameter sets fall here: no latch needed
            isProgErase = 1'b0;
            needsLatch  = 1'b0;
         end
      endcase
   end

   always_comb begin
      next_sr        = sr;
      next_bitCnt    = bitCnt;
      next_shiftIn   = shiftIn;
      next_cmd       = cmd;
      next_cmdValid  = cmdValid;
      next_wrData    = wrData;
      next_dataValid = dataValid;
      next_bitsOdd   = bitsOdd;
      next_reading   = reading;
      next_outShift  = outShift;
      next_serialOut = serialOut;
      next_serialOutEn = reading && ceLow;
      next_op        = op;
      next_startOp   = 1'b0;
      next_startKind = startKind;
      next_lastCmd   = lastCmd;
      next_suspendReq = 1'b0;

      if (!ceLow) begin
         next_bitCnt  = 4'h0;
         next_reading = 1'b0;
      end else if (sckRise) begin
         next_shiftIn = byteNow;
         next_bitCnt  = byteDone ? 4'h0 : bitCnt + 4'h1;
         next_bitsOdd = !byteDone;
         if (byteDone && !cmdValid) begin
            next_cmd      = byteNow;
            next_cmdValid = 1'b1;
            // Reads are served while busy so the host can poll; enable and
            // disable act on the opcode byte itself, not at frame end
            if (byteNow == STATUS_READ_CMD) begin
               next_reading  = 1'b1;
               next_outShift = sr;
            end else if (byteNow == SUSPEND_CMD && sr.busyFlag
                         && op == FSWP_OP_PROG_ERASE) begin
               next_suspendReq = 1'b1;
            end else if (!sr.busyFlag && byteNow == WRITE_ENABLE_CMD) begin
               next_sr.writeEnableLatch = 1'b1;
            end else if (!sr.busyFlag && byteNow == WRITE_DISABLE_CMD) begin
               next_sr.writeEnableLatch = 1'b0;
            end
         end else if (byteDone && !dataValid) begin
            next_wrData    = byteNow;
            next_dataValid = 1'b1;
         end
      end else if (sckFall && reading) begin
         // Shift out MSB first; each byte boundary reloads the live value,
         // so a long poll sees busy drop in the next byte loaded after the operation ends
         if (bitCnt == 4'h0) begin
            next_serialOut = sr[LOCK_BIT];
            next_outShift  = {sr[6:0], 1'b0};
         end else begin
            next_serialOut = outShift[7];
            next_outShift  = {outShift[6:0], 1'b0};
         end
      end

      // A frame cut inside a byte leaves bitsOdd set and launches nothing
      if (ceRise) begin
         next_cmdValid  = 1'b0;
         next_dataValid = 1'b0;
         // Only a whole-byte frame while idle may launch
         if (cmdValid && !bitsOdd && !sr.busyFlag && needsLatch
             && sr.writeEnableLatch) begin
            if (cmd == STATUS_WRITE_CMD) begin
               if (dataValid && !srLocked) begin
                  next_sr = (sr & ~NV_MASK) | (wrData & NV_MASK);
                  next_sr.busyFlag = 1'b1;
                  next_op = FSWP_OP_REG_WRITE;
               end
            end else if (isProgErase) begin
               if ((cmd == CHIP_ERASE_CMD || cmd == CHIP_ERASE_CMD2)
                   ? (sr.protectBits == PROT_NONE)
                   : !regionProtected) begin
                  next_sr.busyFlag = 1'b1;
                  next_op = FSWP_OP_PROG_ERASE;
               end
            end else begin
               next_sr.busyFlag = 1'b1;
               next_op = FSWP_OP_REG_WRITE;
            end
            next_startOp   = next_sr.busyFlag;
            // Held fields follow launches only; a refused frame leaves them
            if (next_sr.busyFlag) begin
               next_startKind = next_op;
               next_lastCmd   = cmd;
            end
         end
      end

      // Launch is gated on idle, so set and clear of busy never collide;
      // suspend keeps the latch so the resumed work needs no new enable
      if (sr.busyFlag && (opDone || suspendReq)) begin
         next_sr.busyFlag         = 1'b0;
         next_sr.writeEnableLatch = suspendReq ? sr.writeEnableLatch
                                               : 1'b0;
         next_op = FSWP_OP_NONE;
      end
   end

   // Registers only; every decision lives in the process above
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sr          <= STATUS_RESET;
         bitCnt      <= 4'h0;
         shiftIn     <= 8'h00;
         cmd         <= 8'h00;
         cmdValid    <= 1'b0;
         wrData      <= 8'h00;
         dataValid   <= 1'b0;
         bitsOdd     <= 1'b0;
         reading     <= 1'b0;
         outShift    <= 8'h00;
         serialOut   <= 1'b0;
         serialOutEn <= 1'b0;
         op          <= FSWP_OP_NONE;
         startOp     <= 1'b0;
         startKind   <= FSWP_OP_NONE;
         lastCmd     <= 8'h00;
         suspendReq  <= 1'b0;
      end else begin
         sr          <= next_sr;
         bitCnt      <= next_bitCnt;
         shiftIn     <= next_shiftIn;
         cmd         <= next_cmd;
         cmdValid    <= next_cmdValid;
         wrData      <= next_wrData;
         dataValid   <= next_dataValid;
         bitsOdd     <= next_bitsOdd;
         reading     <= next_reading;
         outShift    <= next_outShift;
         serialOut   <= next_serialOut;
         serialOutEn <= next_serialOutEn;
         op          <= next_op;
         startOp     <= next_startOp;
         startKind   <= next_startKind;
         lastCmd     <= next_lastCmd;
         suspendReq  <= next_suspendReq;
      end
   end

   // Status is a register, so reads and the pin roles see one value
   assign status = sr;
   // Role flags drop while quad mode is on; srLocked reads the protect pin in every mode
   assign writeProtectActive = !sr.quadEnable;
   assign holdResetActive    = !sr.quadEnable;
endmodule

/* File: rtl/fswp_pkg.sv */
package fswp_pkg;
   localparam logic [7:0] WRITE_ENABLE_CMD       = 8'h06;
   localparam logic [7:0] WRITE_DISABLE_CMD      = 8'h04;
   localparam logic [7:0] STATUS_READ_CMD        = 8'h05;
   localparam logic [7:0] STATUS_WRITE_CMD       = 8'h01;
   localparam logic [7:0] PAGE_PROGRAM_CMD       = 8'h02;
   localparam logic [7:0] QUAD_PAGE_PROGRAM_CMD  = 8'h32;
   localparam logic [7:0] QUAD_PAGE_PROGRAM_CMD2 = 8'h38;
   localparam logic [7:0] SECTOR_ERASE_CMD       = 8'hD7;
   localparam logic [7:0] SECTOR_ERASE_CMD2      = 8'h20;
   localparam logic [7:0] BLOCK32_ERASE_CMD      = 8'h52;
   localparam logic [7:0] BLOCK64_ERASE_CMD      = 8'hD8;
   localparam logic [7:0] CHIP_ERASE_CMD         = 8'hC7;
   localparam logic [7:0] CHIP_ERASE_CMD2        = 8'h60;
   localparam logic [7:0] FUNCTION_REG_WRITE_CMD = 8'h42;
   localparam logic [7:0] NV_READ_PARAM_SET_CMD  = 8'h65;
   localparam logic [7:0] NV_EXT_READ_PARAM_SET_CMD = 8'h85;
   localparam logic [7:0] INFO_ROW_ERASE_CMD     = 8'h64;
   localparam logic [7:0] INFO_ROW_PROGRAM_CMD   = 8'h62;
   localparam logic [7:0] AUTOBOOT_WRITE_CMD     = 8'h15;
   localparam logic [7:0] VOL_READ_PARAM_SET_CMD = 8'hC0;
   localparam logic [7:0] VOL_READ_PARAM_SET_CMD2 = 8'h63;
   localparam logic [7:0] VOL_EXT_READ_PARAM_SET_CMD = 8'h83;
   localparam logic [7:0] FUNCTION_READ_CMD      = 8'h48;
   localparam logic [7:0] EXT_READ_REG_READ_CMD  = 8'h81;
   localparam logic [7:0] SUSPEND_CMD            = 8'h75;
   localparam logic [7:0] RESET_ENABLE_CMD       = 8'h66;
   localparam logic [7:0] SOFT_RESET_CMD         = 8'h99;
   localparam logic [7:0] STATUS_RESET           = 8'h00;
   localparam int         BUSY_BIT               = 0;
   localparam int         WEL_BIT                = 1;
   localparam int         PROT_LSB               = 2;
   localparam int         QE_BIT                 = 6;
   localparam int         LOCK_BIT               = 7;
   localparam logic [7:0] NV_MASK                = 8'hFC;
   localparam logic [3:0] PROT_NONE              = 4'h0;
   localparam logic [3:0] BIT_CNT_LAST           = 4'h7;
   typedef struct packed {
      logic       statusLockBit;
      logic       quadEnable;
      logic [3:0] protectBits;
      logic       writeEnableLatch;
      logic       busyFlag;
   } fswp_status_t;
   typedef enum logic [1:0] {
      FSWP_OP_NONE,
      FSWP_OP_PROG_ERASE,
      FSWP_OP_REG_WRITE
   } fswp_op_t;
endpackage

/* File: testbench/fswp_status_protect_assertions.sv */
`timescale 1ns/10ps
module fswp_sp_checker (
   input wire logic                    ref_clk,
   input wire logic                    rst_n,
   input wire logic                    chipEnableN,
   input wire logic                    protectPinN,
   input wire logic                    opDone,
   input wire fswp_pkg::fswp_status_t  status,
   input wire logic                    startOp,
   input wire fswp_pkg::fswp_op_t      startKind,
   input wire logic [7:0]              lastCmd,
   input wire logic                    suspendReq,
   input wire logic                    writeProtectActive,
   input wire logic                    holdResetActive
);
   import fswp_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_cleared;
      !status.busyFlag && !status.writeEnableLatch;
   endsequence
   sequence s_busy_prog;
      status.busyFlag && startKind == FSWP_OP_PROG_ERASE;
   endsequence
   property p_reset_zero;
      !$past(rst_n) |-> status == STATUS_RESET;
   endproperty
   property p_start_busy;
      startOp |-> status.busyFlag && chipEnableN;
   endproperty
   property p_wel_gate;
      startOp |-> $past(status.writeEnableLatch);
   endproperty
   property p_done;
      opDone && status.busyFlag && !startOp |=> s_cleared;
   endproperty
   // Busy already standing at the previous edge means no new launch
   property p_busy_hold;
      $past(status.busyFlag) && status.busyFlag |-> !startOp;
   endproperty
   property p_chip_erase;
      startOp && (lastCmd == CHIP_ERASE_CMD || lastCmd == CHIP_ERASE_CMD2)
         |-> $past(status.protectBits) == PROT_NONE;
   endproperty
   property p_lock;
      startOp && lastCmd == STATUS_WRITE_CMD
         |-> !$past(status.statusLockBit) || protectPinN;
   endproperty
   property p_nv_only;
      !$stable(status[7:2])
         |-> (startOp || $past(startOp)) && lastCmd == STATUS_WRITE_CMD;
   endproperty
   property p_suspend;
      suspendReq |-> s_busy_prog ##1 !status.busyFlag
         && status.writeEnableLatch;
   endproperty
   property p_quad;
      $stable(status.quadEnable) |-> writeProtectActive == !status.quadEnable
         && holdResetActive == !status.quadEnable;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("status not zero after reset");
   a_start_busy: assert property (p_start_busy)
      else $error("launch without busy or inside frame");
   a_wel_gate: assert property (p_wel_gate)
      else $error("launch without write enable latch");
   a_done: assert property (p_done)
      else $error("busy or latch not cleared at end");
   a_busy_hold: assert property (p_busy_hold)
      else $error("launch while busy");
   a_chip_erase: assert property (p_chip_erase)
      else $error("chip erase with protection set");
   a_lock: assert property (p_lock)
      else $error("status write while locked");
   a_nv_only: assert property (p_nv_only)
      else $error("stored bits changed without status write");
   a_suspend: assert property (p_suspend)
      else $error("suspend handling wrong");
   a_quad: assert property (p_quad)
      else $error("control pin function wrong");
endmodule
bind fswp_status_protect fswp_sp_checker chk (.ref_clk, .rst_n,
   .chipEnableN, .protectPinN, .opDone, .status, .startOp, .startKind,
   .lastCmd, .suspendReq, .writeProtectActive, .holdResetActive);

/* File: testbench/fswp_host_model.sv */
`timescale 1ns/10ps
module fswp_host_model (
   output logic        sckPin,
   output logic        chipEnableN,
   output logic        serialIn,
   input  wire logic   serialOut
);
   logic [31:0] rxData;
   initial begin
      sckPin = 1'b0;
      chipEnableN = 1'b1;
      serialIn = 1'b0;
      rxData = '0;
   end
   // One frame, MSB first; the link clock idles low between frames
   task automatic xfer(input logic [31:0] txData, input int n);
      chipEnableN = 1'b0;
      for (int i = 0; i < n; i++) begin
         serialIn = txData[31 - i];
         #62.5 sckPin = 1'b1;
         rxData = {rxData[30:0], serialOut};
         #62.5 sckPin = 1'b0;
      end
      #62.5 chipEnableN = 1'b1;
      // Released line must not echo the last bit
      serialIn = ~serialIn;
      #200;
   endtask
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
   import fswp_pkg::*;
   logic ref_clk, rst_n, protectPinN, regionProtected, opDone;
   logic sckPin, chipEnableN, serialIn, serialOut, serialOutEn;
   logic startOp, suspendReq, writeProtectActive, holdResetActive;
   fswp_status_t status;
   fswp_op_t     startKind;
   logic [7:0]   lastCmd;
   int badCount = 0, nChecks = 0, nStarts = 0, nSusp = 0, nOe = 0;
   logic [7:0] wOps [15] = '{8'h02, 8'h32, 8'h38, 8'hD7, 8'h20, 8'h52,
      8'hD8, 8'hC7, 8'h60, 8'h42, 8'h65, 8'h85, 8'h64, 8'h62, 8'h15};
   fswp_status_protect dut (.ref_clk, .rst_n, .sckPin, .chipEnableN,
      .serialIn, .protectPinN, .regionProtected, .opDone, .status,
      .serialOut, .serialOutEn, .startOp, .startKind, .lastCmd,
      .suspendReq, .writeProtectActive, .holdResetActive);
   fswp_host_model host (.sckPin, .chipEnableN, .serialIn, .serialOut);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (startOp === 1'b1) nStarts <= nStarts + 1;
      if (suspendReq === 1'b1) nSusp <= nSusp + 1;
      if (serialOutEn === 1'b1) nOe <= nOe + 1;
   end
   task automatic wrapUp;
      if (badCount == 0 && nChecks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] exp,
                        input logic [31:0] got);
      @(negedge ref_clk);
      nChecks++;
      if (got !== exp) begin
         badCount++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cmd(input logic [7:0] op);
      host.xfer({op, 24'h0}, 8);
   endtask
   task automatic status_write_cmd(input logic [7:0] d);
      cmd(WRITE_ENABLE_CMD);
      host.xfer({STATUS_WRITE_CMD, d, 16'h0}, 16);
   endtask
   task automatic finishOp;
      @(posedge ref_clk) opDone <= 1'b1;
      @(posedge ref_clk) opDone <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   initial begin
      #400000;
      badCount++;
      wrapUp();
   end
   initial begin
      rst_n = 1'b0;
      protectPinN = 1'b1;
      regionProtected = 1'b0;
      opDone = 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      check("reset status", 8'h00, status);
      check("control pins", 2'b11, {writeProtectActive, holdResetActive});
      cmd(PAGE_PROGRAM_CMD);
      check("launch without latch", 0, nStarts);
      cmd(WRITE_ENABLE_CMD);
      check("latch set", 8'h02, status);
      cmd(WRITE_DISABLE_CMD);
      check("latch cleared", 8'h00, status);
      status_write_cmd(8'hBF);
      check("status write", 8'hBF, status);
      check("write kind", {FSWP_OP_REG_WRITE, STATUS_WRITE_CMD},
            {startKind, lastCmd});
      cmd(WRITE_DISABLE_CMD);
      host.xfer({STATUS_READ_CMD, 24'h0}, 24);
      check("read while busy", 16'hBFBF, host.rxData[15:0]);
      check("read enable", 2'b10, {nOe > 0, serialOutEn});
      finishOp();
      check("after done", 8'hBC, status);
      cmd(WRITE_ENABLE_CMD);
      cmd(CHIP_ERASE_CMD);
      check("chip erase gated", {8'h01, STATUS_WRITE_CMD},
            {nStarts[7:0], lastCmd});
      @(posedge ref_clk) protectPinN <= 1'b0;
      status_write_cmd(8'h00);
      check("locked write", 8'hBE, status);
      @(posedge ref_clk) protectPinN <= 1'b1;
      host.xfer({STATUS_WRITE_CMD, 24'h0}, 16);
      check("unlocked write", 8'h03, status);
      finishOp();
      @(posedge ref_clk) regionProtected <= 1'b1;
      cmd(WRITE_ENABLE_CMD);
      cmd(PAGE_PROGRAM_CMD);
      check("region inhibit", 8'h02, status);
      @(posedge ref_clk) regionProtected <= 1'b0;
      cmd(PAGE_PROGRAM_CMD);
      cmd(SUSPEND_CMD);
      check("suspend", {8'h02, 8'd1, 8'd3}, {status, nSusp[7:0],
            nStarts[7:0]});
      foreach (wOps[i]) begin
         cmd(WRITE_ENABLE_CMD);
         cmd(wOps[i]);
         check("launch", {8'h03, wOps[i]}, {status, lastCmd});
         finishOp();
      end
      status_write_cmd(8'h40);
      check("quad pins", 2'b00, {writeProtectActive, holdResetActive});
      finishOp();
      wrapUp();
   end
endmodule
